// ===== rtl/sfpp_pkg.sv
// shared constants and types of the serial flash programming port
package sfpp_pkg;
  localparam int          INSTR_BITS   = 32;
  localparam logic [5:0]  BYTE2_END    = 6'h10;
  localparam logic [5:0]  BYTE3_END    = 6'h18;
  localparam logic [5:0]  INSTR_END    = 6'h20;
  localparam logic [15:0] PE_HEAD      = 16'hAC53;
  localparam logic [7:0]  PE_ECHO      = 8'h53;
  localparam logic [7:0]  OP_PREFIX    = 8'hAC;
  localparam logic [7:0]  OP_TIMING    = 8'h5D;
  localparam logic [7:0]  OP_ERASE     = 8'h80;
  localparam logic [7:0]  OP_LOCKW     = 8'hE0;
  localparam logic [7:0]  SUB_MASK     = 8'hE0;
  localparam logic [7:0]  OP_LOAD      = 8'h40;
  localparam logic [7:0]  OP_WRPAGE    = 8'h4C;
  localparam logic [7:0]  OP_READ      = 8'h20;
  localparam logic [7:0]  OP_RDLOCK    = 8'h58;
  localparam logic [7:0]  H_MASK       = 8'hF7;
  localparam int          H_BIT        = 3;
  localparam int          TIM_W        = 6;
  localparam logic [7:0]  BYTE_ERASED  = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  LOCK_RESET   = 8'hFF;
  localparam int          LOCK_RDEN    = 0;
  localparam int          LOCK_SIZE_LO = 1;
  localparam int          LOCK_BOOT    = 4;
  localparam logic [7:0]  PAGE_BYTES   = 8'h80;
  localparam logic [7:0]  BOOT_PAGE    = 8'h00;
  // first protected page per lock size code
  localparam logic [7:0]  TOP_001      = 8'h80;
  localparam logic [7:0]  TOP_010      = 8'hC0;
  localparam logic [7:0]  TOP_011      = 8'hE0;
  localparam logic [7:0]  TOP_100      = 8'hF0;
  localparam logic [7:0]  TOP_101      = 8'hF8;
  localparam logic [7:0]  TOP_110      = 8'hFC;
  // one flash timing tick is 16 clock periods; each timing unit is PAGE_WRITE_UNITS ticks
  localparam int          FLASH_TICK_CYCLES = 16;
  localparam int          DELAY_W      = 24;

  typedef enum logic [2:0] {
    WR_IDLE   = 3'h1,
    WR_STREAM = 3'h2,
    WR_HOLD   = 3'h4
  } sfpp_wr_state_t;
endpackage

// ===== rtl/sfpp_page_buf.sv
// 128-byte page buffer with registered read data
`timescale 1ns/1ps
module sfpp_page_buf (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // write port
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // read port
  input  wire logic       rd_en,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data
);
  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0]        rd;
  } sfpp_buf_st_t;

  sfpp_buf_st_t st_reg;
  sfpp_buf_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      st_next.rd = st_reg.mem[rd_addr];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd;
endmodule

// ===== rtl/sfpp_top.sv
// serial flash programming port: link decoder, page buffer control and flash sequencer
// Notes on behaviour
// - four bytes per instruction, msb first
// - only enable instruction accepted until enabled
// - aligned device echoes 0x53 during byte three
// - unaligned device returns zeros in byte three
// - timing value taken from fourth byte
// - chip erase sets all flash and locks
// - load stores byte at seven bit address
// - write page programs whole buffer to page
// - reads return 0xFF while write busy
// - read returns flash byte in byte four
// - boot lock protects page zero when low
// - lock size protects top flash region
// - read enable low makes reads return zero unless write busy
// - port active only while mode pin low
// - sample on rising, shift on falling edge
// - instructions decoded from first two bytes
// - lock writes are anded with existing locks
`timescale 1ns/1ps
module sfpp_top #(
  parameter int PAGE_WRITE_UNITS = 256
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // serial link pins
  input  wire logic        program_mode_select_n,
  input  wire logic        sck,
  input  wire logic        si,
  output logic             so,
  // flash macro: erase and read
  output logic             flash_erase_all,
  output logic             flash_rd_en,
  output logic      [14:0] flash_rd_addr,
  input  wire logic [7:0]  flash_rdata,
  // flash macro: page write stream
  output logic             flash_wvalid,
  input  wire logic        flash_wready,
  output logic      [14:0] flash_waddr,
  output logic      [7:0]  flash_wdata,
  // status
  output logic             flash_busy,
  output logic      [7:0]  flash_lock_byte
);
  typedef struct packed {
    logic                        sck_m, sck_s, sck_d, si_m, si_s, program_mode_select_n_m, program_mode_select_n_s;
    logic                        enabled;
    logic [4:0]                  bitcnt;
    logic [31:0]                 shin;
    logic [7:0]                  shout;
    logic                        so;
    logic                        rd_pend;
    logic                        rd_en;
    logic [14:0]                 rd_addr;
    logic                        erase;
    logic [sfpp_pkg::TIM_W-1:0]  flash_timing_value;
    logic [7:0]                  lock;
    sfpp_pkg::sfpp_wr_state_t    state;
    logic [7:0]                  page;
    logic [7:0]                  idx;
    logic                        pend;
    logic [6:0]                  pidx;
    logic [1:0][7:0]             f_dat;
    logic [1:0][6:0]             f_adr;
    logic                        wp, rp;
    logic [1:0]                  cnt;
    logic [sfpp_pkg::DELAY_W-1:0] delay;
  } sfpp_st_t;

  localparam logic [sfpp_pkg::DELAY_W-1:0] HOLD_PER_UNIT =
    sfpp_pkg::DELAY_W'(PAGE_WRITE_UNITS * sfpp_pkg::FLASH_TICK_CYCLES);

  sfpp_st_t    st_reg;
  sfpp_st_t    st_next;
  logic [31:0] sh;
  logic [5:0]  cnt1;
  logic        rise, fall, is_rd24, is_head16, prot_hit;
  logic        buf_we, buf_re, push, pop;
  logic [6:0]  buf_waddr;
  logic [7:0]  buf_wdata, buf_rdata;

  // write protection per page from lock byte
  function automatic logic page_locked(input logic [7:0] pg, input logic [7:0] lk);
    logic [2:0] sz;
    logic       top;
    sz  = lk[sfpp_pkg::LOCK_SIZE_LO +: 3];
    top = 1'b0;
    case (sz)
      3'h0:    top = 1'b1;
      3'h1:    top = (pg >= sfpp_pkg::TOP_001);
      3'h2:    top = (pg >= sfpp_pkg::TOP_010);
      3'h3:    top = (pg >= sfpp_pkg::TOP_011);
      3'h4:    top = (pg >= sfpp_pkg::TOP_100);
      3'h5:    top = (pg >= sfpp_pkg::TOP_101);
      3'h6:    top = (pg >= sfpp_pkg::TOP_110);
      default: top = 1'b0;
    endcase
    page_locked = top || (pg == sfpp_pkg::BOOT_PAGE && !lk[sfpp_pkg::LOCK_BOOT]);
  endfunction

  sfpp_page_buf u_buf (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wr_en   (buf_we),
    .wr_addr (buf_waddr),
    .wr_data (buf_wdata),
    .rd_en   (buf_re),
    .rd_addr (st_reg.idx[6:0]),
    .rd_data (buf_rdata)
  );

  always_comb begin
    st_next   = st_reg;
    buf_we    = 1'b0;
    buf_waddr = '0;
    buf_wdata = '0;
    st_next.erase = 1'b0;
    st_next.rd_en = 1'b0;
    // two-stage synchronisers on pins
    st_next.sck_m  = sck;
    st_next.sck_s  = st_reg.sck_m;
    st_next.sck_d  = st_reg.sck_s;
    st_next.si_m   = si;
    st_next.si_s   = st_reg.si_m;
    st_next.program_mode_select_n_m = program_mode_select_n;
    st_next.program_mode_select_n_s = st_reg.program_mode_select_n_m;
    rise = st_reg.sck_s && !st_reg.sck_d;
    fall = !st_reg.sck_s && st_reg.sck_d;
    sh   = {st_reg.shin[30:0], st_reg.si_s};
    cnt1 = {1'b0, st_reg.bitcnt} + 6'h01;
    is_head16 = (sh[15:0] == sfpp_pkg::PE_HEAD);
    is_rd24   = ((sh[23:16] & sfpp_pkg::H_MASK) == sfpp_pkg::OP_READ);
    prot_hit  = page_locked(sh[23:16], st_reg.lock);
    if (st_reg.program_mode_select_n_s) begin
      st_next.enabled = 1'b0;
      st_next.bitcnt  = '0;
      st_next.shout   = '0;
      st_next.so      = 1'b0;
      st_next.rd_pend = 1'b0;
    end else if (rise) begin
      st_next.shin   = sh;
      st_next.bitcnt = cnt1[4:0];
      if (cnt1 == sfpp_pkg::BYTE2_END) begin
        st_next.shout = is_head16 ? sfpp_pkg::PE_ECHO : sfpp_pkg::BYTE_ZERO;
      end else if (cnt1 == sfpp_pkg::BYTE3_END) begin
        st_next.shout = sfpp_pkg::BYTE_ZERO;
        if (st_reg.enabled && is_rd24) begin
          if (st_reg.state != sfpp_pkg::WR_IDLE) begin
            st_next.shout = sfpp_pkg::BYTE_ERASED;
          end else if (st_reg.lock[sfpp_pkg::LOCK_RDEN]) begin
            st_next.rd_en   = 1'b1;
            st_next.rd_addr = {sh[15:8], sh[7:2], sh[16 + sfpp_pkg::H_BIT]};
            st_next.rd_pend = 1'b1;
          end
        end else if (st_reg.enabled && sh[23:16] == sfpp_pkg::OP_RDLOCK) begin
          st_next.shout = st_reg.lock;
        end
      end else if (cnt1 == sfpp_pkg::INSTR_END) begin
        if (!st_reg.enabled) begin
          st_next.enabled = (sh[31:16] == sfpp_pkg::PE_HEAD);
        end else if (st_reg.state == sfpp_pkg::WR_IDLE) begin
          if (sh[31:24] == sfpp_pkg::OP_PREFIX) begin
            if (sh[23:16] == sfpp_pkg::OP_TIMING) begin
              st_next.flash_timing_value = sh[sfpp_pkg::TIM_W-1:0];
            end else if ((sh[23:16] & sfpp_pkg::SUB_MASK) == sfpp_pkg::OP_ERASE) begin
              st_next.erase = 1'b1;
              st_next.lock  = sfpp_pkg::LOCK_RESET;
            end else if ((sh[23:16] & sfpp_pkg::SUB_MASK) == sfpp_pkg::OP_LOCKW) begin
              st_next.lock = st_reg.lock & sh[7:0];
            end
          end else if ((sh[31:24] & sfpp_pkg::H_MASK) == sfpp_pkg::OP_LOAD) begin
            buf_we    = 1'b1;
            buf_waddr = {sh[15:10], sh[24 + sfpp_pkg::H_BIT]};
            buf_wdata = sh[7:0];
          end else if (sh[31:24] == sfpp_pkg::OP_WRPAGE && !prot_hit) begin
            st_next.state = sfpp_pkg::WR_STREAM;
            st_next.page  = sh[23:16];
            st_next.idx   = '0;
          end
        end
      end
    end else if (fall) begin
      st_next.so    = st_reg.shout[7];
      st_next.shout = {st_reg.shout[6:0], 1'b0};
    end
    if (st_reg.rd_pend && !st_reg.program_mode_select_n_s) begin
      st_next.rd_pend = 1'b0;
      st_next.shout   = flash_rdata;
    end
    // page stream through the two-entry buffer
    pop    = (st_reg.cnt != 2'h0) && flash_wready;
    push   = st_reg.pend;
    buf_re = (st_reg.state == sfpp_pkg::WR_STREAM) && (st_reg.idx < sfpp_pkg::PAGE_BYTES) &&
             ({1'b0, st_reg.cnt} + {2'h0, st_reg.pend} < 3'h2);
    st_next.pend = buf_re;
    if (buf_re) begin
      st_next.pidx = st_reg.idx[6:0];
      st_next.idx  = st_reg.idx + 8'h01;
    end
    if (push) begin
      st_next.f_dat[st_reg.wp] = buf_rdata;
      st_next.f_adr[st_reg.wp] = st_reg.pidx;
      st_next.wp = !st_reg.wp;
    end
    if (pop) begin
      st_next.rp = !st_reg.rp;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    case (st_reg.state)
      sfpp_pkg::WR_IDLE: begin
      end
      sfpp_pkg::WR_STREAM: begin
        if (st_reg.idx == sfpp_pkg::PAGE_BYTES && !st_reg.pend && st_reg.cnt == 2'h0) begin
          st_next.state = sfpp_pkg::WR_HOLD;
          st_next.delay = sfpp_pkg::DELAY_W'(st_reg.flash_timing_value) * HOLD_PER_UNIT;
        end
      end
      sfpp_pkg::WR_HOLD: begin
        if (st_reg.delay <= sfpp_pkg::DELAY_W'(1)) begin
          st_next.state = sfpp_pkg::WR_IDLE;
        end else begin
          st_next.delay = st_reg.delay - sfpp_pkg::DELAY_W'(1);
        end
      end
      default: st_next.state = sfpp_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_reg        <= '0;
      st_reg.sck_m  <= 1'b0;
      st_reg.program_mode_select_n_m <= 1'b1;
      st_reg.program_mode_select_n_s <= 1'b1;
      st_reg.lock   <= sfpp_pkg::LOCK_RESET;
      st_reg.state  <= sfpp_pkg::WR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign so              = st_reg.so;
  assign flash_erase_all = st_reg.erase;
  assign flash_rd_en     = st_reg.rd_en;
  assign flash_rd_addr   = st_reg.rd_addr;
  assign flash_wvalid    = (st_reg.cnt != 2'h0);
  assign flash_waddr     = {st_reg.page, st_reg.f_adr[st_reg.rp]};
  assign flash_wdata     = st_reg.f_dat[st_reg.rp];
  assign flash_busy      = (st_reg.state != sfpp_pkg::WR_IDLE);
  assign flash_lock_byte = st_reg.lock;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_bit(logic [4:0] n);
    rise && !st_reg.program_mode_select_n_s && st_reg.bitcnt == n;
  endsequence
  sequence s_last_beat;
    flash_wvalid && flash_wready && st_reg.idx == sfpp_pkg::PAGE_BYTES && st_reg.cnt == 2'h1 && !st_reg.pend;
  endsequence

  property p_inactive;
    st_reg.program_mode_select_n_s |=> !st_reg.enabled && !st_reg.so;
  endproperty
  a_inactive: assert property (p_inactive) else $error("port active while mode pin high");
  property p_echo;
    s_bit(5'h0F) ##0 is_head16 |=> st_reg.shout == 8'h53;
  endproperty
  a_echo: assert property (p_echo) else $error("missing enable echo");
  property p_noecho;
    s_bit(5'h0F) ##0 !is_head16 |=> st_reg.shout == 8'h00;
  endproperty
  a_noecho: assert property (p_noecho) else $error("echo while unaligned");
  property p_busy_read;
    s_bit(5'h17) ##0 (st_reg.enabled && is_rd24 && flash_busy) |=> st_reg.shout == 8'hFF;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read not 0xFF");
  property p_read_disabled;
    s_bit(5'h17) ##0 (st_reg.enabled && is_rd24 && !flash_busy && !st_reg.lock[0])
      |=> st_reg.shout == 8'h00 && !st_reg.rd_en;
  endproperty
  a_read_disabled: assert property (p_read_disabled) else $error("read not blanked");
  property p_read_data;
    flash_rd_en && !st_reg.program_mode_select_n_s |=> st_reg.shout == $past(flash_rdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not loaded");
  property p_lock_and;
    (|(st_reg.lock & ~$past(st_reg.lock))) |-> st_reg.erase;
  endproperty
  a_lock_and: assert property (p_lock_and) else $error("lock bit rose without erase");
  property p_erase;
    st_reg.erase |-> st_reg.lock == 8'hFF && st_reg.enabled;
  endproperty
  a_erase: assert property (p_erase) else $error("erase left locks set");
  property p_gate;
    !st_reg.enabled |-> !buf_we && !(rise && cnt1 == 6'h20 && st_next.state == sfpp_pkg::WR_STREAM
      && st_reg.state == sfpp_pkg::WR_IDLE);
  endproperty
  a_gate: assert property (p_gate) else $error("command before enable");
  property p_protect;
    s_bit(5'h1F) ##0 (st_reg.enabled && !flash_busy && sh[31:24] == 8'h4C && prot_hit) |=> !flash_busy;
  endproperty
  a_protect: assert property (p_protect) else $error("protected page written");
  property p_stream_end;
    s_last_beat |=> st_reg.state == sfpp_pkg::WR_HOLD || st_reg.state == sfpp_pkg::WR_STREAM ##1
      st_reg.state != sfpp_pkg::WR_STREAM;
  endproperty
  a_stream_end: assert property (p_stream_end) else $error("page stream did not close");
endmodule

// ===== sim/sfpp_flash_model.sv
// behavioural flash macro facing the port's flash interface
`timescale 1ns/1ps
module sfpp_flash_model (
  // clock
  input  wire logic        clk_sys,
  // erase and read
  input  wire logic        flash_erase_all,
  input  wire logic        flash_rd_en,
  input  wire logic [14:0] flash_rd_addr,
  output logic      [7:0]  flash_rdata,
  // page write stream
  input  wire logic        flash_wvalid,
  output logic             flash_wready,
  input  wire logic [14:0] flash_waddr,
  input  wire logic [7:0]  flash_wdata
);
  logic [7:0] mem [0:32767];
  logic [7:0] rd_q  = 8'h00;
  logic [1:0] phase = 2'h0;
  // stalls one beat in four
  assign flash_wready = (phase != 2'h3);
  // read data valid while the request stands, since the port samples it then
  assign flash_rdata  = flash_rd_en ? mem[flash_rd_addr] : rd_q;
  always_ff @(posedge clk_sys) begin
    phase <= phase + 2'h1;
    if (flash_erase_all) begin
      for (int i = 0; i < 32768; i++) begin
        mem[i] <= 8'hFF;
      end
    end else if (flash_wvalid && flash_wready) begin
      mem[flash_waddr] <= flash_wdata;
    end
    // scrambled outside a request
    rd_q <= ~flash_rdata;
  end
endmodule

// ===== sim/sfpp_top_tb.sv
// self-checking bench for the serial flash programming port
`timescale 1ns/1ps
module sfpp_top_tb;
  logic        clk_sys               = 1'b0;
  logic        reset_n               = 1'b0;
  logic        program_mode_select_n = 1'b1;
  logic        sck                   = 1'b0;
  logic        si                    = 1'b0;
  logic        so;
  logic        erase;
  logic        rd_en;
  logic        wvalid;
  logic        wready;
  logic        busy;
  logic [14:0] rd_addr;
  logic [14:0] waddr;
  logic [7:0]  rdata;
  logic [7:0]  wdata;
  logic [7:0]  lock;
  int          fails      = 0;
  int          n_compared = 0;

  always #20 clk_sys = ~clk_sys;

  sfpp_top #(.PAGE_WRITE_UNITS(1)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .program_mode_select_n(program_mode_select_n),
    .sck(sck), .si(si), .so(so),
    .flash_erase_all(erase), .flash_rd_en(rd_en), .flash_rd_addr(rd_addr), .flash_rdata(rdata),
    .flash_wvalid(wvalid), .flash_wready(wready), .flash_waddr(waddr), .flash_wdata(wdata),
    .flash_busy(busy), .flash_lock_byte(lock)
  );

  sfpp_flash_model u_flash (
    .clk_sys(clk_sys), .flash_erase_all(erase), .flash_rd_en(rd_en), .flash_rd_addr(rd_addr),
    .flash_rdata(rdata), .flash_wvalid(wvalid), .flash_wready(wready), .flash_waddr(waddr),
    .flash_wdata(wdata)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one instruction msb first; so sampled just before each rise
  task automatic instr(input logic [31:0] cmd, output logic [7:0] b3, output logic [7:0] b4);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 31; i >= 0; i--) begin
      sck = 1'b0;
      si  = cmd[i];
      // first bit of byte four waits for read data
      clks((i == 7) ? 10 : 4);
      r[i] = so;
      sck  = 1'b1;
      clks(4);
    end
    sck = 1'b0;
    clks(4);
    b3 = r[15:8];
    b4 = r[7:0];
  endtask

  task automatic rd(input logic [7:0] pg, input logic [6:0] k, output logic [7:0] d);
    logic [7:0] e3;
    instr({4'h2, k[0], 3'h0, pg, k[6:1], 2'h0, 8'h00}, e3, d);
  endtask

  task automatic wpage(input logic [7:0] pg, input logic exp_busy);
    logic [7:0] e3;
    logic [7:0] e4;
    instr({8'h4C, pg, 16'h0000}, e3, e4);
    check({7'h00, busy}, {7'h00, exp_busy});
  endtask

  task automatic wait_idle;
    for (int n = 0; n < 4000 && busy !== 1'b0; n++) begin
      clks(1);
    end
    if (busy !== 1'b0) begin
      fails++;
      close_out();
    end
  endtask

  initial begin
    clks(90000);
    fails++;
    close_out();
  end

  initial begin
    logic [7:0] e3;
    logic [7:0] e4;
    int         n;
    clks(8);
    reset_n = 1'b1;
    clks(3);
    check(lock, 8'hFF);
    check({7'h00, busy}, 8'h00);
    program_mode_select_n = 1'b0;
    clks(4);
    // one stray pulse leaves the port misaligned
    sck = 1'b1;
    clks(4);
    sck = 1'b0;
    clks(4);
    instr(32'hAC53_0000, e3, e4);
    check(e3, 8'h00);
    // one slip pulse per retry until the echo shows
    for (n = 1; n < 32 && e3 !== 8'h53; n++) begin
      sck = 1'b1;
      clks(4);
      sck = 1'b0;
      clks(4);
      instr(32'hAC53_0000, e3, e4);
    end
    check(e3, 8'h53);
    program_mode_select_n = 1'b1;
    clks(4);
    program_mode_select_n = 1'b0;
    clks(4);
    instr(32'hACE0_0000, e3, e4);
    check(e3, 8'h00);
    instr(32'hAC53_0000, e3, e4);
    check(e3, 8'h53);
    check(lock, 8'hFF);
    instr(32'hAC5D_0020, e3, e4);
    instr(32'hAC80_0000, e3, e4);
    // erase is untimed here; a short settle stands in for the wait
    clks(8);
    for (int k = 0; k < 128; k++) begin
      instr({4'h4, k[0], 3'h0, 8'h00, k[6:1], 2'h0, k[7:0] ^ 8'h5A}, e3, e4);
    end
    wpage(8'h03, 1'b1);
    rd(8'h03, 7'h00, e4);
    check(e4, 8'hFF);
    for (n = 0; n < 12 && e4 === 8'hFF; n++) begin
      rd(8'h03, 7'h00, e4);
    end
    check(e4, 8'h5A);
    rd(8'h03, 7'h01, e4);
    check(e4, 8'h5B);
    rd(8'h03, 7'h7F, e4);
    check(e4, 8'h25);
    instr(32'hACE0_001D, e3, e4);
    instr(32'h5800_0000, e3, e4);
    check(e4, 8'h1D);
    wpage(8'hFC, 1'b0);
    wpage(8'hFB, 1'b1);
    wait_idle();
    instr(32'hACE0_000F, e3, e4);
    check(lock, 8'h0D);
    wpage(8'h00, 1'b0);
    instr(32'hACE0_001C, e3, e4);
    rd(8'h03, 7'h01, e4);
    check(e4, 8'h00);
    instr(32'hAC80_0000, e3, e4);
    check(lock, 8'hFF);
    rd(8'h03, 7'h01, e4);
    check(e4, 8'hFF);
    close_out();
  end
endmodule
